// ===== logic/lnf_pkg.sv
package lnf_pkg;

  // Register addresses
  localparam logic [11:0] CTRL_ONE_ADDR = 12'hF43;
  localparam logic [11:0] AUX_CTRL_ADDR = 12'hF44;
  localparam logic [11:0] STATUS_ADDR   = 12'hF45;
  localparam logic [11:0] MASK_ADDR     = 12'hF46;

  // Layout select codes
  localparam logic [2:0] LAYOUT_FILTER = 3'h1;
  localparam logic [2:0] LAYOUT_LIN    = 3'h2;

  // Auxiliary control field positions
  localparam int AUX_LAYOUT_LSB = 0;
  localparam int AUX_MULTIPROC_ENABLE_BIT_BIT   = 3;
  localparam int AUX_PEN_BIT    = 4;

  // Status bit positions
  localparam int ST_AUTOBAUD_BIT = 0;
  localparam int ST_BREAK_BIT    = 1;
  localparam int ST_WIDTH        = 2;

  // Reset values
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] AUX_RESET    = 8'h00;
  localparam logic [1:0] STAT_RESET   = 2'h0;
  localparam logic [10:0] CNT_RESET   = 11'h000;

  // Filter counter
  localparam logic [10:0] CNT_FULL_MAX = 11'h7FF;
  localparam logic [2:0]  WIDTH_CODE_MAX = 3'h7;

  // Break length
  localparam logic [1:0] BRK_CODE_13 = 2'h0;
  localparam logic [1:0] BRK_CODE_14 = 2'h1;
  localparam logic [3:0] BRK_BITS_13 = 4'hD;
  localparam logic [3:0] BRK_BITS_14 = 4'hE;

  typedef enum logic [1:0] {
    LNF_SLEEP    = 2'h0,
    LNF_WAIT_BRK = 2'h1,
    LNF_AUTOBAUD = 2'h2,
    LNF_ACTIVE   = 2'h3
  } lnf_state_t;

  typedef struct packed {
    logic       en;
    logic [2:0] width;
  } lnf_filter_t;

  typedef struct packed {
    logic       master;
    logic       slave;
    logic       ab_en;
    logic       ab_ie;
    lnf_state_t state;
    logic [1:0] brk;
  } lnf_lin_t;

endpackage

// ===== logic/lnf_ctrl.sv
// Operation
// R1 - Layout code 001 maps the filter layout onto the shared control address.
// R2 - Layout code 010 maps the LIN control layout onto the shared address.
// R3 - Filter enable routes receive data through the filter, else bypass.
// R4 - Width code 000 to 111 selects a 4 to 11 bit counter.
// R5 - Wider counter gives longer delay and rejects longer noise pulses.
// R6 - Software writes zeros to filter layout bits 3:0; they read zero.
// R7 - Master select gives master mode only with multiproc, parity, slave clear.
// R8 - Slave select gives slave mode only with multiproc, parity, master clear.
// R9 - Autobaud enable acts only in slave mode.
// R10 - Autobaud done with interrupt enable raises receive interrupt and done flag.
// R11 - Autobaud done without interrupt enable raises no interrupt.
// R12 - State codes: 00 sleep, 01 wait break, 10 autobaud, 11 active.
// R13 - Slave hardware advances wait break, autobaud, active after software start.
// R14 - Master break length: code 00 13 bit times, code 01 14.
// R15 - Counter follows raw input, saturates; output flips only at full or empty.
`timescale 1ns/100ps
module lnf_ctrl (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Line side and receiver events
  input  wire logic        rx_raw,
  input  wire logic        break_seen,
  input  wire logic        ab_char_done,
  // Receiver and mode outputs
  output logic             rxd_filt,
  output logic             lin_master_on,
  output logic             lin_slave_on,
  output logic             autobaud_on,
  output logic      [1:0]  lin_state,
  output logic      [3:0]  break_bits,
  output logic             rx_irq,
  output logic             irq
);

  lnf_pkg::lnf_filter_t nf_q, nf_d;
  lnf_pkg::lnf_lin_t    lin_q, lin_d;
  logic [7:0]  aux_q, aux_d;
  logic [1:0]  stat_q, stat_d, mask_q, mask_d;
  logic [7:0]  rdata_q, rdata_d;
  logic [10:0] cnt_q, cnt_d, lim;
  logic        filt_q, filt_d, rxd_q, rxd_d;
  logic        mst_q, mst_d, slv_q, slv_d, abon_q, abon_d;
  logic [3:0]  brk_q, brk_d;
  logic        rxirq_q, rxirq_d, irq_q, irq_d;
  logic [2:0]  layout;
  logic        multiproc_enable_bit, parity_enable_bit, wr_ctrl, slave_mode, ab_done, brk_evt;

  assign layout     = aux_q[lnf_pkg::AUX_LAYOUT_LSB +: 3];
  assign multiproc_enable_bit       = aux_q[lnf_pkg::AUX_MULTIPROC_ENABLE_BIT_BIT];
  assign parity_enable_bit        = aux_q[lnf_pkg::AUX_PEN_BIT];
  assign wr_ctrl    = reg_wr && (reg_addr == lnf_pkg::CTRL_ONE_ADDR);
  assign slave_mode = lin_q.slave && !lin_q.master && !multiproc_enable_bit && !parity_enable_bit; // [R8]
  assign ab_done    = slave_mode && lin_q.ab_en && (lin_q.state == lnf_pkg::LNF_AUTOBAUD) && ab_char_done; // [R9]
  assign brk_evt    = slave_mode && (lin_q.state == lnf_pkg::LNF_WAIT_BRK) && break_seen;

  // Register writes, sticky status, interrupt
  always_comb begin
    nf_d   = nf_q;
    lin_d  = lin_q;
    aux_d  = aux_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (wr_ctrl && layout == lnf_pkg::LAYOUT_FILTER) begin // [R1]
      nf_d = reg_wdata[7:4]; // [R6]
    end
    if (reg_wr && reg_addr == lnf_pkg::AUX_CTRL_ADDR) begin
      aux_d = {3'h0, reg_wdata[4:0]};
    end
    if (reg_wr && reg_addr == lnf_pkg::MASK_ADDR) begin
      mask_d = reg_wdata[1:0];
    end
    if (reg_wr && reg_addr == lnf_pkg::STATUS_ADDR) begin
      stat_d = stat_q & ~reg_wdata[1:0];
    end
    // Hardware sequencing of the slave
    if (brk_evt) begin // [R13]
      lin_d.state = (lin_q.ab_en) ? lnf_pkg::LNF_AUTOBAUD : lnf_pkg::LNF_ACTIVE;
    end else if (slave_mode && lin_q.state == lnf_pkg::LNF_AUTOBAUD && (ab_done || !lin_q.ab_en)) begin // [R13]
      lin_d.state = lnf_pkg::LNF_ACTIVE;
    end
    if (wr_ctrl && layout == lnf_pkg::LAYOUT_LIN) begin // [R2]
      lin_d = reg_wdata; // [R12]
    end
    if (ab_done && lin_q.ab_ie) begin // [R10]
      stat_d[lnf_pkg::ST_AUTOBAUD_BIT] = 1'b1;
    end
    if (brk_evt) begin
      stat_d[lnf_pkg::ST_BREAK_BIT] = 1'b1;
    end
    rxirq_d = ab_done && lin_q.ab_ie; // [R10] [R11]
    irq_d   = |(stat_d & mask_d);
  end

  // Read data, one cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        lnf_pkg::CTRL_ONE_ADDR: begin
          if (layout == lnf_pkg::LAYOUT_FILTER) begin
            rdata_d = {nf_q, 4'h0}; // [R1] [R6]
          end else if (layout == lnf_pkg::LAYOUT_LIN) begin
            rdata_d = lin_q; // [R2]
          end else begin
            rdata_d = 8'h00;
          end
        end
        lnf_pkg::AUX_CTRL_ADDR: rdata_d = aux_q;
        lnf_pkg::STATUS_ADDR:   rdata_d = {6'h00, stat_q};
        lnf_pkg::MASK_ADDR:     rdata_d = {6'h00, mask_q};
        default:                rdata_d = 8'h00;
      endcase
    end
  end

  // Noise filter
  always_comb begin
    lim   = lnf_pkg::CNT_FULL_MAX >> (lnf_pkg::WIDTH_CODE_MAX - nf_q.width); // [R4]
    cnt_d = cnt_q;
    if (cnt_q > lim) begin
      cnt_d = lim;
    end else if (rx_raw && cnt_q != lim) begin // [R15]
      cnt_d = cnt_q + 11'h001;
    end else if (!rx_raw && cnt_q != 11'h000) begin // [R15]
      cnt_d = cnt_q - 11'h001;
    end
    filt_d = filt_q;
    if (cnt_d == lim) begin // [R5] [R15]
      filt_d = 1'b1;
    end else if (cnt_d == 11'h000) begin
      filt_d = 1'b0;
    end
    rxd_d = nf_q.en ? filt_q : rx_raw; // [R3]
  end

  // Mode decode
  always_comb begin
    mst_d  = lin_q.master && !lin_q.slave && !multiproc_enable_bit && !parity_enable_bit; // [R7]
    slv_d  = slave_mode; // [R8]
    abon_d = slave_mode && lin_q.ab_en; // [R9]
    case (lin_q.brk)
      lnf_pkg::BRK_CODE_13: brk_d = lnf_pkg::BRK_BITS_13; // [R14]
      lnf_pkg::BRK_CODE_14: brk_d = lnf_pkg::BRK_BITS_14; // [R14]
      default:              brk_d = lnf_pkg::BRK_BITS_13;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nf_q    <= lnf_pkg::CTRL_RESET[7:4];
      lin_q   <= lnf_pkg::CTRL_RESET;
      aux_q   <= lnf_pkg::AUX_RESET;
      stat_q  <= lnf_pkg::STAT_RESET;
      mask_q  <= lnf_pkg::STAT_RESET;
      rdata_q <= 8'h00;
      cnt_q   <= lnf_pkg::CNT_RESET;
      filt_q  <= 1'b0;
      rxd_q   <= 1'b0;
      mst_q   <= 1'b0;
      slv_q   <= 1'b0;
      abon_q  <= 1'b0;
      brk_q   <= lnf_pkg::BRK_BITS_13;
      rxirq_q <= 1'b0;
      irq_q   <= 1'b0;
    end else begin
      nf_q    <= nf_d;
      lin_q   <= lin_d;
      aux_q   <= aux_d;
      stat_q  <= stat_d;
      mask_q  <= mask_d;
      rdata_q <= rdata_d;
      cnt_q   <= cnt_d;
      filt_q  <= filt_d;
      rxd_q   <= rxd_d;
      mst_q   <= mst_d;
      slv_q   <= slv_d;
      abon_q  <= abon_d;
      brk_q   <= brk_d;
      rxirq_q <= rxirq_d;
      irq_q   <= irq_d;
    end
  end

  assign reg_rdata     = rdata_q;
  assign rxd_filt      = rxd_q;
  assign lin_master_on = mst_q;
  assign lin_slave_on  = slv_q;
  assign autobaud_on   = abon_q;
  assign lin_state     = lin_q.state;
  assign break_bits    = brk_q;
  assign rx_irq        = rxirq_q;
  assign irq           = irq_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_filter_layout_read: assert property ( // [R1]
    reg_rd && reg_addr == lnf_pkg::CTRL_ONE_ADDR && layout == lnf_pkg::LAYOUT_FILTER
    |=> reg_rdata[7:4] == $past(nf_q))
    else $error("filter layout read mismatch");

  a_lin_layout_read: assert property ( // [R2]
    reg_rd && reg_addr == lnf_pkg::CTRL_ONE_ADDR && layout == lnf_pkg::LAYOUT_LIN
    |=> reg_rdata == $past(lin_q))
    else $error("lin layout read mismatch");

  a_filter_bypass: assert property ( // [R3]
    !nf_q.en |=> rxd_filt == $past(rx_raw))
    else $error("bypass does not follow raw input");

  a_counter_limit: assert property ( // [R4]
    nf_q.en && $stable(nf_q.width) |=> cnt_q <= (11'h00F << $past(nf_q.width)) + ~(11'h7FF << $past(nf_q.width)))
    else $error("filter counter beyond width");

  a_filter_rise_full: assert property ( // [R5]
    $rose(filt_q) |-> cnt_q == lim || $past(cnt_q) > $past(lim))
    else $error("filter output rose before counter full");

  a_reserved_zero: assert property ( // [R6]
    reg_rd && reg_addr == lnf_pkg::CTRL_ONE_ADDR && layout == lnf_pkg::LAYOUT_FILTER
    |=> reg_rdata[3:0] == 4'h0)
    else $error("reserved bits not zero");

  a_master_gate: assert property ( // [R7]
    lin_master_on |-> $past(lin_q.master && !lin_q.slave && !multiproc_enable_bit && !parity_enable_bit))
    else $error("master mode without its conditions");

  a_slave_gate: assert property ( // [R8]
    lin_slave_on |-> !lin_master_on && $past(!multiproc_enable_bit && !parity_enable_bit && !lin_q.master))
    else $error("slave mode without its conditions");

  a_autobaud_slave: assert property ( // [R9]
    autobaud_on |-> lin_slave_on)
    else $error("autobaud active outside slave mode");

  a_autobaud_irq: assert property ( // [R10]
    ab_done && lin_q.ab_ie |=> rx_irq && stat_q[lnf_pkg::ST_AUTOBAUD_BIT] ##1 (!rx_irq || $past(ab_done && lin_q.ab_ie)))
    else $error("autobaud completion not flagged");

  a_autobaud_quiet: assert property ( // [R11]
    !(ab_done && lin_q.ab_ie) |=> !rx_irq)
    else $error("interrupt without autobaud enable");

  a_slave_advance: assert property ( // [R13]
    brk_evt && !wr_ctrl |=> lin_state != lnf_pkg::LNF_WAIT_BRK)
    else $error("slave did not leave wait for break");

  a_break_length: assert property ( // [R14]
    lin_q.brk == lnf_pkg::BRK_CODE_14 && $stable(lin_q.brk) |=> break_bits == lnf_pkg::BRK_BITS_14)
    else $error("break length mismatch");

  a_filter_write: assert property ( // [R1]
    wr_ctrl && layout == lnf_pkg::LAYOUT_FILTER |=> nf_q == $past(reg_wdata[7:4]))
    else $error("filter layout write lost");

  a_lin_write: assert property ( // [R2]
    wr_ctrl && layout == lnf_pkg::LAYOUT_LIN |=> lin_q == $past(reg_wdata))
    else $error("lin layout write lost");

  a_filter_fall_empty: assert property ( // [R15]
    $fell(filt_q) |-> cnt_q == 11'h000)
    else $error("filter output fell before counter empty");

  a_autobaud_skip: assert property ( // [R9]
    slave_mode && !lin_q.ab_en && lin_q.state == lnf_pkg::LNF_AUTOBAUD && !wr_ctrl
    |=> lin_state == lnf_pkg::LNF_ACTIVE)
    else $error("autobaud state held without autobaud enable");

  a_status_sticky: assert property ( // [R10]
    stat_q[lnf_pkg::ST_AUTOBAUD_BIT]
    && !(reg_wr && reg_addr == lnf_pkg::STATUS_ADDR && reg_wdata[lnf_pkg::ST_AUTOBAUD_BIT])
    |=> stat_q[lnf_pkg::ST_AUTOBAUD_BIT])
    else $error("autobaud done flag lost without clear");

  a_irq_level: assert property ( // [R10]
    irq == |(stat_q & mask_q))
    else $error("interrupt level differs from unmasked status");

  a_state_hold: assert property ( // [R13]
    !slave_mode && !wr_ctrl |=> $stable(lin_q.state))
    else $error("state moved outside slave mode");

  a_wait_break_hold: assert property ( // [R13]
    slave_mode && lin_q.state == lnf_pkg::LNF_WAIT_BRK && !break_seen && !wr_ctrl
    |=> lin_state == lnf_pkg::LNF_WAIT_BRK)
    else $error("slave left wait for break without a break");

  a_break_default: assert property ( // [R14]
    lin_q.brk == lnf_pkg::BRK_CODE_13 |=> break_bits == lnf_pkg::BRK_BITS_13)
    else $error("short break length mismatch");

  c_autobaud_done: cover property (ab_done && lin_q.ab_ie);
  c_filter_toggle: cover property (nf_q.en && $rose(rxd_filt));
  c_slave_active:  cover property (slave_mode && lin_state == lnf_pkg::LNF_ACTIVE);
  c_irq_raised:    cover property ($rose(irq));
  c_master_on:     cover property ($rose(lin_master_on));

endmodule

// ===== tb/lnf_line_model.sv
`timescale 1ns/100ps
module lnf_line_model (
  // Clock
  input  wire logic clk,
  // Line side
  output logic      rx_raw,
  output logic      break_seen,
  output logic      ab_char_done
);
  initial begin
    rx_raw       = 1'b1;
    break_seen   = 1'b0;
    ab_char_done = 1'b0;
  end
  // Line level for n cycles
  task automatic level(input logic v, input int n);
    @(posedge clk) rx_raw <= v;
    repeat (n - 1) @(posedge clk);
  endtask
  // Break, then autobaud character
  task automatic brk();
    @(posedge clk) break_seen <= 1'b1;
    @(posedge clk) break_seen <= 1'b0;
  endtask
  task automatic abc();
    @(posedge clk) ab_char_done <= 1'b1;
    @(posedge clk) ab_char_done <= 1'b0;
  endtask
endmodule

// ===== tb/lnf_ctrl_tb_top.sv
`timescale 1ns/100ps
module lnf_ctrl_tb_top;
  logic        clk       = 1'b0;
  logic        nrst      = 1'b0;
  logic [11:0] reg_addr  = 12'h000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [7:0]  reg_rdata;
  logic        rx_raw, break_seen, ab_char_done, rxd_filt, rx_irq, irq;
  logic        lin_master_on, lin_slave_on, autobaud_on;
  logic [1:0]  lin_state;
  logic [3:0]  break_bits;
  int          hi_cnt    = 0;
  int          hi_base;
  int          err_count = 0;
  int          compares  = 0;
  int          pulses    = 0;
  int          lim, n;
  // Aux, control, expected {master, slave, autobaud}
  logic [23:0] modes [7] = '{24'h028004, 24'h0A8000, 24'h124000, 24'h02C000,
                             24'h026003, 24'h02A004, 24'h022000};

  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (rx_irq === 1'b1) pulses <= pulses + 1;
    if (rxd_filt === 1'b1) hi_cnt <= hi_cnt + 1;
  end

  lnf_ctrl u_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_raw(rx_raw), .break_seen(break_seen),
    .ab_char_done(ab_char_done), .rxd_filt(rxd_filt), .lin_master_on(lin_master_on),
    .lin_slave_on(lin_slave_on), .autobaud_on(autobaud_on), .lin_state(lin_state),
    .break_bits(break_bits), .rx_irq(rx_irq), .irq(irq));
  lnf_line_model u_line (.clk(clk), .rx_raw(rx_raw), .break_seen(break_seen), .ab_char_done(ab_char_done));

  task automatic give_verdict();
    if (err_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input string what, input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(what, exp, reg_rdata);
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    chk("break_bits", 8'h0D, {4'h0, break_bits});
    nrst <= 1'b1;
    rd("aux", 12'hF44, 8'h00);
    rd("ctrl_none", 12'hF43, 8'h00);
    rd("unmapped", 12'h000, 8'h00);
    wr(12'hF44, 8'h01);
    rd("filter_rst", 12'hF43, 8'h00);
    wr(12'hF43, 8'hF0);
    rd("filter", 12'hF43, 8'hF0);
    wr(12'hF44, 8'h02);
    rd("lin_rst", 12'hF43, 8'h00);
    wr(12'hF46, 8'h01);
    rd("mask", 12'hF46, 8'h01);
    // Bypass
    wr(12'hF44, 8'h01);
    wr(12'hF43, 8'h00);
    u_line.level(1'b0, 3);
    u_line.level(1'b1, 2);
    #1 chk("bypass_hi", 8'h01, rxd_filt);
    u_line.level(1'b0, 2);
    #1 chk("bypass_lo", 8'h00, rxd_filt);
    // Every width code
    for (int c = 0; c < 8; c++) begin
      lim = (16 << c) - 1;
      wr(12'hF43, {1'b1, c[2:0], 4'h0});
      u_line.level(1'b0, lim + 4);
      hi_base = hi_cnt;
      u_line.level(1'b1, lim - 1);
      u_line.level(1'b0, lim + 4);
      chk("short_pulse", 8'h00, {7'h00, hi_cnt != hi_base});
      u_line.level(1'b1, 1);
      for (n = 0; n < lim + 8 && rxd_filt !== 1'b1; n++) begin
        @(posedge clk);
        #1;
      end
      if (rxd_filt !== 1'b1) begin
        err_count++;
        give_verdict();
      end
      chk("filt_delay", 8'h01, (n >= lim && n <= lim + 3));
    end
    // Mode selection
    for (int i = 0; i < 7; i++) begin
      wr(12'hF44, modes[i][23:16]);
      wr(12'hF43, modes[i][15:8]);
      step(3);
      chk("mode", modes[i][7:0], {5'h00, lin_master_on, lin_slave_on, autobaud_on});
    end
    wr(12'hF43, 8'h81);
    step(3);
    chk("break_14", 8'h0E, {4'h0, break_bits});
    wr(12'hF43, 8'h80);
    step(3);
    chk("break_13", 8'h0D, {4'h0, break_bits});
    // Slave autobaud with interrupt
    wr(12'hF46, 8'h00);
    wr(12'hF43, 8'h00);
    wr(12'hF43, 8'h74);
    step(2);
    n = pulses;
    u_line.brk();
    step(2);
    chk("state_ab", 8'h02, {6'h00, lin_state});
    u_line.abc();
    step(3);
    chk("state_act", 8'h03, {6'h00, lin_state});
    chk("rx_irq", 8'h01, 8'(pulses - n));
    rd("status", 12'hF45, 8'h03);
    chk("irq_masked", 8'h00, irq);
    wr(12'hF46, 8'h01);
    step(2);
    chk("irq_on", 8'h01, irq);
    wr(12'hF45, 8'h01);
    step(2);
    chk("irq_off", 8'h00, irq);
    rd("status_clr", 12'hF45, 8'h02);
    rd("lin_ctrl", 12'hF43, 8'h7C);
    // Autobaud without interrupt
    wr(12'hF43, 8'h00);
    wr(12'hF43, 8'h64);
    step(2);
    u_line.brk();
    step(2);
    u_line.abc();
    step(3);
    chk("no_irq", 8'h01, 8'(pulses - n));
    rd("no_flag", 12'hF45, 8'h02);
    chk("state_act2", 8'h03, {6'h00, lin_state});
    give_verdict();
  end
endmodule
